// file: hdl/slow_msg_gen.sv
/*
 Slow-channel message content and status/fast-channel diagnostic
 signalling for one sensor channel.
 Assumes a downstream serializer pops message words and builds the
 frames; all inputs come from logic on CLK_IN, so none is synchronised.
*/
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module slow_msg_gen #(
   parameter int FIFO_DEPTH = 32,
   parameter int CODE_COUNT = 8
) (
   input wire logic CLK_IN,
   input wire logic RESET_IN,
   input wire slow_msg_pkg::cfg_t CFG_IN,
   input wire logic DIAG_MODE_IN,
   input wire slow_msg_pkg::warn_t WARN_IN,
   input wire logic [10:0] SAFETY_FLAGS_IN,
   input wire logic [11:0] ANGLE_IN,
   input wire logic [8:0] VOLTAGE_IN,
   input wire logic [7:0] TEMP_IN,
   input wire logic [CODE_COUNT*12-1:0] CUSTOMER_CODES_IN,
   input wire logic MSG_READY_IN,
   output logic MSG_VALID_OUT,
   output slow_msg_pkg::msg_t MSG_OUT,
   output logic [1:0] STATUS_BITS_OUT,
   output logic [11:0] FAST_DATA_OUT
);
   import slow_msg_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Declarations
   logic [1:0] status_ff, nxt_status;
   logic [11:0] fast_ff, nxt_fast;
   logic [4:0] slot_ff, nxt_slot;
   logic out_valid_ff, nxt_out_valid;
   msg_t out_word_ff, nxt_out_word;
   msg_t cur_msg, fifo_rd_word;
   logic [11:0] status_code, type_code, rev_code;
   logic [11:0] codes [CODE_COUNT];
   logic prewarn, push, fifo_wr_ready, fifo_rd_valid, pop;

   // Unpack the customer code words, one per message slot
   for (genvar i = 0; i < CODE_COUNT; i++) begin : g_code
      assign codes[i] = CUSTOMER_CODES_IN[i*12 +: 12];
   end

   ////////////////////////////////////////////////////////////////////
   // Status nibble bits and fast-channel value

   // Pre-warning only counts while still in normal mode
   assign prewarn = !DIAG_MODE_IN && (|WARN_IN);

   // Status bits are kept apart from the data; checksum never sees them
   always_comb begin
      nxt_status = STATUS_RESET;
      nxt_status[STAT_DIAG_POS] = DIAG_MODE_IN && !CFG_IN.mask_diag_bit;
      nxt_status[STAT_WARN_POS] = prewarn && !CFG_IN.mask_prewarn_bit;
      nxt_fast = ANGLE_IN;
      if (DIAG_MODE_IN) begin
         unique case (CFG_IN.format)
            FMT_A1: nxt_fast = DIAG_VALUE_A;
            FMT_A3: nxt_fast = ANGLE_IN;
            FMT_H1, FMT_H3, FMT_H4: nxt_fast = DIAG_VALUE_H;
            default: nxt_fast = ANGLE_IN;      // Unused format codes
         endcase
      end
   end

   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         status_ff <= STATUS_RESET;
         fast_ff <= FAST_RESET;
      end else begin
         status_ff <= nxt_status;
         fast_ff <= nxt_fast;
      end
   end

   assign STATUS_BITS_OUT = status_ff;
   assign FAST_DATA_OUT = fast_ff;

   ////////////////////////////////////////////////////////////////////
   // Message content

   // Detailed status code; first listed condition wins
   always_comb begin
      if (DIAG_MODE_IN) begin
         status_code = {1'b1, SAFETY_FLAGS_IN[10:2],
                        SAFETY_FLAGS_IN[1], SAFETY_FLAGS_IN[0]};
      end else if (WARN_IN.above_range_limit) begin
         status_code = CODE_ABOVE_RANGE;
      end else if (WARN_IN.below_range_limit) begin
         status_code = CODE_BELOW_RANGE;
      end else if (WARN_IN.under_volt) begin
         status_code = CODE_UNDER;
      end else if (WARN_IN.over_volt) begin
         status_code = CODE_OVER;
      end else if (WARN_IN.over_temp) begin
         status_code = CODE_TEMP;
      end else if (WARN_IN.memory_error_detect) begin
         status_code = CODE_MEM;
      end else begin
         status_code = CODE_OK;
      end
   end

   // Category 1100b is unassigned and sends zero, as 1101b to 1111b do
   always_comb begin
      unique case (CFG_IN.sensor_category)
         4'h0: type_code = 12'h051;
         4'h1: type_code = 12'h052;
         4'h2: type_code = 12'h053;
         4'h3: type_code = 12'h054;
         4'h4: type_code = 12'h055;
         4'h5: type_code = 12'h056;
         4'h6: type_code = 12'h059;
         4'h7: type_code = 12'h05a;
         4'h8: type_code = 12'h062;
         4'h9: type_code = 12'h063;
         4'ha: type_code = 12'h064;
         4'hb: type_code = 12'h066;
         default: type_code = 12'h000;
      endcase
      unique case (CFG_IN.protocol_revision_select)
         2'h0: rev_code = 12'h000;
         2'h1: rev_code = 12'h002;
         2'h2: rev_code = 12'h003;
         2'h3: rev_code = 12'h004;
      endcase
   end

   // Word for the current schedule slot
   always_comb begin
      cur_msg.id = SCHED[slot_ff];
      cur_msg.data = CODE_OK;
      unique case (SCHED[slot_ff])
         ID_STATUS: cur_msg.data = status_code;
         ID_TYPE: cur_msg.data = type_code;
         ID_MAKER: cur_msg.data = MAKER_CODE;
         ID_REV: cur_msg.data = rev_code;
         ID_VOLT: cur_msg.data = {3'h0, VOLTAGE_IN};
         ID_TEMP: cur_msg.data = {4'h0, TEMP_IN};
         ID_IDENT: cur_msg.data = CFG_IN.channel_identity_bit ? IDENT_ONE : IDENT_ZERO;
         default: cur_msg.data = codes[3'(SCHED[slot_ff] - ID_CODE_BASE)];
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Schedule walker: stalls while the queue is full

   assign push = CFG_IN.extended_serial_enable && fifo_wr_ready;

   always_comb begin
      nxt_slot = slot_ff;
      if (!CFG_IN.extended_serial_enable) begin
         nxt_slot = SLOT_RESET;   // Restart cleanly when re-enabled
      end else if (push) begin
         nxt_slot = (slot_ff == SLOT_LAST) ? SLOT_RESET : slot_ff + 1'b1;
      end
   end

   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         slot_ff <= SLOT_RESET;
      end else begin
         slot_ff <= nxt_slot;
      end
   end

   // Payload is latched into the queue at push; later input changes are harmless
   msg_fifo #(
      .WIDTH($bits(msg_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(CLK_IN),
      .reset_in(RESET_IN),
      .wr_data_in(cur_msg),
      .wr_valid_in(push),
      .wr_ready_out(fifo_wr_ready),
      .rd_data_out(fifo_rd_word),
      .rd_valid_out(fifo_rd_valid),
      .rd_ready_in(pop)
   );

   ////////////////////////////////////////////////////////////////////
   // Output stage, so the serializer sees flip-flops only

   assign pop = fifo_rd_valid && (!out_valid_ff || MSG_READY_IN);

   always_comb begin
      nxt_out_valid = out_valid_ff;
      nxt_out_word = out_word_ff;
      if (pop) begin
         nxt_out_valid = 1'b1;
         nxt_out_word = fifo_rd_word;
      end else if (MSG_READY_IN) begin
         nxt_out_valid = 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         out_valid_ff <= 1'b0;
         out_word_ff <= '0;
      end else begin
         out_valid_ff <= nxt_out_valid;
         out_word_ff <= nxt_out_word;
      end
   end

   assign MSG_VALID_OUT = out_valid_ff;
   assign MSG_OUT = out_word_ff;

   ////////////////////////////////////////////////////////////////////
   // Assertions

   a_diag_bit_set: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      DIAG_MODE_IN && !CFG_IN.mask_diag_bit |=> STATUS_BITS_OUT[0])
      else $error("diag bit not set in diagnostic mode");

   a_diag_mask_zero: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      CFG_IN.mask_diag_bit |=> !STATUS_BITS_OUT[0])
      else $error("masked diag bit not zero");

   a_warn_normal_only: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      STATUS_BITS_OUT[1] |-> !$past(DIAG_MODE_IN) && ($past(WARN_IN) != '0))
      else $error("pre-warning without cause or in diagnostic mode");

   a_warn_mask_zero: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      CFG_IN.mask_prewarn_bit |=> !STATUS_BITS_OUT[1])
      else $error("masked pre-warning bit not zero");

   a_fast_subst: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      DIAG_MODE_IN && (CFG_IN.format inside {FMT_H1, FMT_H3, FMT_H4}) |=> FAST_DATA_OUT == 12'hffa)
      else $error("H format diagnostic value wrong");

   a_fast_a1: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      DIAG_MODE_IN && (CFG_IN.format == FMT_A1) |=> FAST_DATA_OUT == 12'hfff)
      else $error("A.1 diagnostic value wrong");

   a_push_needs_enable: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      !CFG_IN.extended_serial_enable |-> !push ##1 (slot_ff == 5'h00))
      else $error("message queued with serial protocol disabled");

   a_sched_wrap: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      push && (slot_ff == 5'h11) |=> (slot_ff == 5'h00) && (cur_msg.id == 8'h01))
      else $error("schedule did not wrap after 18 messages");

   a_volt_range: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      push && (cur_msg.id == 8'h1c) |-> cur_msg.data < 12'h200)
      else $error("voltage code out of range");

   a_temp_range: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      push && (cur_msg.id == 8'h23) |-> cur_msg.data < 12'h100)
      else $error("temperature code out of range");

   a_ident_map: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      push && (cur_msg.id == 8'h29) |->
      cur_msg.data == (CFG_IN.channel_identity_bit ? 12'hfff : 12'h000))
      else $error("identity code wrong");

   a_out_hold: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      MSG_VALID_OUT && !MSG_READY_IN |=> MSG_VALID_OUT && $stable(MSG_OUT))
      else $error("message word changed before it was taken");

   a_fast_normal: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      !DIAG_MODE_IN |=> FAST_DATA_OUT == $past(ANGLE_IN))
      else $error("normal mode fast value is not the angle");

   a_fast_a3: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      DIAG_MODE_IN && (CFG_IN.format == FMT_A3) |=> FAST_DATA_OUT == $past(ANGLE_IN))
      else $error("A.3 diagnostic value is not the angle");

   // Content checks on words as they enter the queue
   a_status_safety: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      push && (cur_msg.id == ID_STATUS) && DIAG_MODE_IN |->
      cur_msg.data == {1'b1, SAFETY_FLAGS_IN})
      else $error("safety error code wrong");

   a_maker_fixed: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      push && (cur_msg.id == ID_MAKER) |-> cur_msg.data == MAKER_CODE)
      else $error("manufacturer code not fixed");

   a_code_first: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      push && (cur_msg.id == ID_CODE_BASE) |-> cur_msg.data == CUSTOMER_CODES_IN[11:0])
      else $error("first customer code wrong");

   a_rev_map: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      push && (cur_msg.id == ID_REV) && (CFG_IN.protocol_revision_select == 2'h3) |->
      cur_msg.data == 12'h004)
      else $error("revision code wrong");

endmodule : slow_msg_gen

// file: shared/slow_msg_pkg.sv
/*
 Shared types and constants for the slow-channel content generator:
 message IDs, the message schedule, fixed codes and diagnostic values.
 Assumes a single clock domain; no timing figures live here.
*/
package slow_msg_pkg;

   // Enhanced-format message word: 8-bit ID, 12-bit data
   typedef struct packed {
      logic [7:0] id;
      logic [11:0] data;
   } msg_t;

   // Fast-channel protocol formats
   typedef enum logic [2:0] {
      FMT_A1 = 3'b000,
      FMT_A3 = 3'b001,
      FMT_H1 = 3'b010,
      FMT_H3 = 3'b011,
      FMT_H4 = 3'b100
   } fmt_t;

   // Static configuration, from the shadow copy of the setup memory
   typedef struct packed {
      logic extended_serial_enable;    // First protocol config word
      logic mask_diag_bit;             // Second protocol config word
      logic mask_prewarn_bit;          // Second protocol config word
      fmt_t format;
      logic [1:0] protocol_revision_select;
      logic [3:0] sensor_category;
      logic channel_identity_bit;
   } cfg_t;

   // Pre-warning conditions from the threshold monitors
   typedef struct packed {
      logic above_range_limit;
      logic below_range_limit;
      logic under_volt;
      logic over_volt;
      logic over_temp;
      logic memory_error_detect;       // Corrected single-bit error
   } warn_t;

   // Message IDs
   localparam logic [7:0] ID_STATUS = 8'h01;
   localparam logic [7:0] ID_TYPE = 8'h03;
   localparam logic [7:0] ID_MAKER = 8'h05;
   localparam logic [7:0] ID_REV = 8'h06;
   localparam logic [7:0] ID_VOLT = 8'h1c;
   localparam logic [7:0] ID_TEMP = 8'h23;
   localparam logic [7:0] ID_IDENT = 8'h29;
   localparam logic [7:0] ID_CODE_BASE = 8'h90;
   localparam logic [7:0] ID_CODE_LAST = 8'h97;

   // Schedule of one cycle of the slow channel
   localparam int SCHED_LEN = 18;
   localparam logic [4:0] SLOT_LAST = 5'h11;
   localparam logic [4:0] SLOT_RESET = 5'h00;
   localparam logic [7:0] SCHED [SCHED_LEN] = '{
      8'h01, 8'h23, 8'h1c, 8'h03, 8'h29, 8'h05, 8'h06, 8'h01, 8'h23,
      8'h1c, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97};

   // Maker code: value is arbitrary, not tied to any real part
   localparam logic [11:0] MAKER_CODE = 12'h5a5;

   // Diagnostic status code values
   localparam logic [11:0] CODE_OK = 12'h000;
   localparam logic [11:0] CODE_ABOVE_RANGE = 12'h001;
   localparam logic [11:0] CODE_BELOW_RANGE = 12'h002;
   localparam logic [11:0] CODE_UNDER = 12'h020;
   localparam logic [11:0] CODE_OVER = 12'h021;
   localparam logic [11:0] CODE_TEMP = 12'h022;
   localparam logic [11:0] CODE_MEM = 12'h023;

   // Fast-channel substitutes in diagnostic mode
   localparam logic [11:0] DIAG_VALUE_A = 12'hfff;
   localparam logic [11:0] DIAG_VALUE_H = 12'hffa;

   // Status nibble bit positions and reset values
   localparam int STAT_DIAG_POS = 0;
   localparam int STAT_WARN_POS = 1;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [11:0] FAST_RESET = 12'h000;
   localparam logic [11:0] IDENT_ONE = 12'hfff;
   localparam logic [11:0] IDENT_ZERO = 12'h000;

endpackage : slow_msg_pkg

// file: hdl/msg_fifo.sv
/*
 Word FIFO with flip-flop storage, valid/ready on both sides.
 Assumes both sides run on the same clock; read data is combinational
 from the entry at the read index.
*/
`timescale 1ns/1ps
module msg_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 32
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] nxt_mem [DEPTH];
   logic [AW-1:0] wr_idx_ff, nxt_wr_idx, rd_idx_ff, nxt_rd_idx;
   logic [CW-1:0] count_ff, nxt_count;
   logic do_wr, do_rd;

   // Honest flags straight from the occupancy count
   assign wr_ready_out = (count_ff != CW'(DEPTH));
   assign rd_valid_out = (count_ff != '0);
   assign rd_data_out = mem_ff[rd_idx_ff];
   assign do_wr = wr_valid_in && wr_ready_out;
   assign do_rd = rd_ready_in && rd_valid_out;

   // Pointer and count next values
   always_comb begin
      nxt_wr_idx = wr_idx_ff;
      nxt_rd_idx = rd_idx_ff;
      nxt_count = count_ff;
      if (do_wr) begin
         nxt_wr_idx = (wr_idx_ff == AW'(DEPTH - 1)) ? '0 : wr_idx_ff + 1'b1;
      end
      if (do_rd) begin
         nxt_rd_idx = (rd_idx_ff == AW'(DEPTH - 1)) ? '0 : rd_idx_ff + 1'b1;
      end
      if (do_wr && !do_rd) begin
         nxt_count = count_ff + 1'b1;
      end else if (do_rd && !do_wr) begin
         nxt_count = count_ff - 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         wr_idx_ff <= '0;
         rd_idx_ff <= '0;
         count_ff <= '0;
      end else begin
         wr_idx_ff <= nxt_wr_idx;
         rd_idx_ff <= nxt_rd_idx;
         count_ff <= nxt_count;
      end
   end

   // One storage entry per index
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_comb begin
         nxt_mem[i] = mem_ff[i];
         if (do_wr && (wr_idx_ff == AW'(i))) begin
            nxt_mem[i] = wr_data_in;
         end
      end

      always_ff @(posedge clk_in or posedge reset_in) begin
         if (reset_in) begin
            mem_ff[i] <= '0;
         end else begin
            mem_ff[i] <= nxt_mem[i];
         end
      end
   end

endmodule : msg_fifo

// file: tb/sent_rx_model.sv
/*
 Behavioural slow-channel receiver that pops message words.
 Assumes the generator clock; slow_in paces ready to one edge in four.
*/
`timescale 1ns/1ps
module sent_rx_model (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic slow_in,
   input wire logic valid_in,
   input wire slow_msg_pkg::msg_t msg_in,
   output logic ready_out
);
   import slow_msg_pkg::*;
   msg_t rx_q[$];
   logic [1:0] pace_ff;
   ////////////////////////////////////////////////////////////////////////
   // Whole words only; status bits are judged apart from the payload
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pace_ff <= 2'h0;
         ready_out <= 1'b0;
      end else begin
         pace_ff <= pace_ff + 2'h1;
         ready_out <= !slow_in || (pace_ff == 2'h2); // Stall keeps the queue full
         if (valid_in && ready_out) begin
            rx_q.push_back(msg_in);
         end
      end
   end
endmodule : sent_rx_model

// file: tb/sent_slow_channel_diag_content_test.sv
/*
 Self-checking bench for the slow-channel content generator.
 Assumes a shortened queue depth; words are collected by the receiver model.
*/
`timescale 1ns/1ps
`define CHECK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end
module sent_slow_channel_diag_content_test;
   import slow_msg_pkg::*;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   cfg_t cfg = '0;
   logic diag = 1'b0;
   warn_t warn = '0;
   logic [10:0] safety = '0;
   logic [11:0] angle = '0;
   logic [8:0] volt = '0;
   logic [7:0] temp = '0;
   logic [95:0] codes = '0;
   logic slow = 1'b0;
   logic ready;
   logic valid;
   msg_t msg;
   logic [1:0] stat;
   logic [11:0] fast;
   int fail_count = 0;
   int total_checks = 0;
   logic [7:0] order [18] = '{8'h01, 8'h23, 8'h1c, 8'h03, 8'h29, 8'h05, 8'h06, 8'h01,
      8'h23, 8'h1c, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97};
   logic [11:0] type_tab [16] = '{12'h051, 12'h052, 12'h053, 12'h054, 12'h055, 12'h056,
      12'h059, 12'h05a, 12'h062, 12'h063, 12'h064, 12'h066, 12'h000, 12'h000, 12'h000,
      12'h000};
   logic [11:0] rev_tab [4] = '{12'h000, 12'h002, 12'h003, 12'h004};

   always #12.5 clk_in = !clk_in;

   ////////////////////////////////////////////////////////////////////////
   // Short queue so stale payloads drain quickly
   slow_msg_gen #(.FIFO_DEPTH(4), .CODE_COUNT(8)) i_dut (
      .CLK_IN(clk_in), .RESET_IN(reset_in), .CFG_IN(cfg), .DIAG_MODE_IN(diag),
      .WARN_IN(warn), .SAFETY_FLAGS_IN(safety), .ANGLE_IN(angle), .VOLTAGE_IN(volt),
      .TEMP_IN(temp), .CUSTOMER_CODES_IN(codes), .MSG_READY_IN(ready),
      .MSG_VALID_OUT(valid), .MSG_OUT(msg), .STATUS_BITS_OUT(stat),
      .FAST_DATA_OUT(fast));
   sent_rx_model i_rx (.clk_in(clk_in), .reset_in(reset_in), .slow_in(slow),
      .valid_in(valid), .msg_in(msg), .ready_out(ready));

   ////////////////////////////////////////////////////////////////////////
   // Inputs always move 2 ns after the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask : step

   function automatic logic [11:0] exp_data(input logic [7:0] id);
      case (id)
         8'h01: begin
            if (diag) return {1'b1, safety};
            if (warn.above_range_limit) return 12'h001;
            if (warn.below_range_limit) return 12'h002;
            if (warn.under_volt) return 12'h020;
            if (warn.over_volt) return 12'h021;
            if (warn.over_temp) return 12'h022;
            if (warn.memory_error_detect) return 12'h023;
            return 12'h000;
         end
         8'h23: return {4'h0, temp};
         8'h1c: return {3'h0, volt};
         8'h03: return type_tab[cfg.sensor_category];
         8'h29: return cfg.channel_identity_bit ? 12'hfff : 12'h000;
         8'h05: return MAKER_CODE;
         8'h06: return rev_tab[cfg.protocol_revision_select];
         default: return codes[(id - 8'h90) * 12 +: 12];
      endcase
   endfunction : exp_data

   // Every format, diag and mask combination against the fast/status path
   task automatic run_fast();
      logic [11:0] ef;
      for (int f = 0; f < 6; f++) begin
         for (int k = 0; k < 16; k++) begin
            cfg.format = fmt_t'(3'(f));
            diag = k[0];
            cfg.mask_diag_bit = k[1];
            cfg.mask_prewarn_bit = k[2];
            warn = k[3] ? warn_t'(6'(1 << f)) : '0;
            angle = 12'(f * 700 + k);
            step(2);
            ef = (diag && f == 0) ? 12'hfff : (diag && f >= 2 && f <= 4) ? 12'hffa : angle;
            `CHECK(fast, ef)
            `CHECK(stat[0], diag && !k[1])
            `CHECK(stat[1], !diag && k[3] && !k[2])
         end
      end
   endtask : run_fast

   // Drain, confirm silence while disabled, then one full schedule
   task automatic run_sched(input int i);
      int n;
      msg_t m;
      cfg.extended_serial_enable = 1'b0;
      step(60);
      i_rx.rx_q.delete();
      step(20);
      `CHECK(i_rx.rx_q.size(), 0)
      cfg.sensor_category = 4'(i);
      cfg.protocol_revision_select = 2'(i);
      cfg.channel_identity_bit = i[0];
      diag = i[1];
      warn = warn_t'(6'(1 << (i % 7)));
      safety = 11'(i * 97 + 2);
      volt = 9'h1ff - 9'(i * 33);
      temp = 8'hff - 8'(i * 17);
      for (int k = 0; k < 8; k++) codes[k * 12 +: 12] = 12'hfff ^ 12'(i * k * 91);
      slow = i[2];
      step(2);
      cfg.extended_serial_enable = 1'b1;
      n = 0;
      while (i_rx.rx_q.size() < 18 && n < 600) begin
         step(1);
         n++;
      end
      `CHECK(i_rx.rx_q.size() >= 18, 1'b1)
      for (int k = 0; k < 18 && k < i_rx.rx_q.size(); k++) begin
         m = i_rx.rx_q[k];
         `CHECK(m.id, order[k])
         `CHECK(m.data, exp_data(m.id))
      end
   endtask : run_sched

   task automatic check_reset();
      `CHECK(valid, 1'b0)
      `CHECK(msg, 20'h00000)
      `CHECK(stat, 2'h0)
      `CHECK(fast, 12'h000)
   endtask : check_reset

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////
   // Watchdog well beyond the expected run length
   initial begin
      #(40000 * 25);
      fail_count++;
      complete_run();
   end

   initial begin
      step(20);
      check_reset();
      reset_in = 1'b0;
      step(2);
      run_fast();
      // Mid-run reset clears every output
      diag = 1'b1;
      reset_in = 1'b1;
      step(2);
      check_reset();
      reset_in = 1'b0;
      cfg.format = FMT_A1;
      cfg.mask_diag_bit = 1'b0;
      cfg.mask_prewarn_bit = 1'b0;
      for (int i = 0; i < 16; i++) run_sched(i);
      complete_run();
   end
endmodule : sent_slow_channel_diag_content_test
